// ---- common/dac_link_regs.svh ----
`ifndef DAC_LINK_REGS_SVH
`define DAC_LINK_REGS_SVH

// -----------------------------------------------------------------
// command word layout
// -----------------------------------------------------------------
`define WORD_BITS         24
`define COMMAND_CODE_MSB  21
`define COMMAND_CODE_LSB  19
`define CHANNEL_ADDR_MSB  18
`define CHANNEL_ADDR_LSB  16
`define POWER_MODE_HI     5
`define POWER_MODE_LO     4

// -----------------------------------------------------------------
// command codes and channel addresses
// -----------------------------------------------------------------
`define CMD_WRITE_IN      3'h0
`define CMD_UPDATE_N      3'h1
`define CMD_WRITE_UPD_ALL 3'h2
`define CMD_WRITE_UPD_N   3'h3
`define CMD_POWER         3'h4
`define CMD_RESET         3'h5
`define CMD_LOAD_MODE     3'h6
`define ADDR_CH_A         3'h0
`define ADDR_CH_B         3'h1
`define ADDR_ALL          3'h7

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define LOAD_MODE_RESET   2'h0

// -----------------------------------------------------------------
// host register map and serial timing
// -----------------------------------------------------------------
`define HOST_REG_WORD     8'h00
`define HOST_REG_STROBE   8'h04
`define HOST_REG_STATUS   8'h08
`define SYS_CLK_NS        100
`define SER_HALF_NS       400
`define SER_HALF_CYCLES   ((`SER_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

// ---- common/dac_link_pkg.sv ----
package dac_link_pkg;
   typedef logic [1:0][15:0] code_pair_t;
   typedef enum logic [1:0] {
      PWR_NORMAL,
      PWR_1K_GND,
      PWR_100K_GND,
      PWR_TRISTATE
   } power_mode_t;
   typedef power_mode_t [1:0] power_pair_t;
   typedef enum logic [2:0] {
      H_IDLE,
      H_LEAD,
      H_RISE,
      H_FALL,
      H_GAP
   } host_state_t;
endpackage : dac_link_pkg

// ---- common/dac_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
   logic frame_sync_n;
   logic ser_clk;
   logic ser_data;
   logic load_strobe_n;
   modport device (input frame_sync_n, ser_clk, ser_data, load_strobe_n);
   modport host   (output frame_sync_n, ser_clk, ser_data, load_strobe_n);
endinterface : dac_link_if
`default_nettype wire

// ---- verilog/dac_device.sv ----
// Function
// - input and output register per channel
// - strobe high keeps output registers latched
// - strobe low copies input into output
// - update output only if input rewritten
// - host writes one, strobes during other
// - strobe low: update after 24th edge
// - strobe high: update only on fall
// - mode bit one forces synchronous update
// - command 110 loads per-channel load mode
// - load mode bits reset to zero
// - setup word ignores don't-care bits
// - power word sets selected channels' mode
// - host sends most significant bit first
// - frame sync stays low whole word
// - data valid at falling clock edge
// - word: pad, command, address, data
// - power mode field four encodings
// - reset with bit0 clears modes too
// - early frame sync rise discards word
//
// Local design decisions: the register offsets and the strobed register port.
`include "dac_link_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dac_device (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   dac_link_if.device              link,
   output logic                    word_done,
   output dac_link_pkg::code_pair_t in_code,
   output dac_link_pkg::code_pair_t out_code,
   output dac_link_pkg::power_pair_t power_mode,
   output logic [1:0]              load_mode
);
   import dac_link_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  sync_s;    // frame sync synchroniser
      logic [1:0]  clk_s;     // serial clock synchroniser
      logic [1:0]  data_s;    // serial data synchroniser
      logic [1:0]  strb_s;    // load strobe synchroniser
      logic        clk_prev;
      logic        strb_prev;
      logic [23:0] shift;
      logic [4:0]  count;
      logic        done;
      code_pair_t  in_reg;
      code_pair_t  out_reg;
      logic [1:0]  dirty;
      power_pair_t pwr;
      logic [1:0]  mode;
   } dev_state_t;

   dev_state_t q_reg;
   dev_state_t q_next;

   logic        clk_fall;
   logic        strobe_fall;
   logic        done_now;
   logic [23:0] word;
   logic [2:0]  cmd;
   logic [2:0]  addr;
   logic [15:0] data;
   logic [1:0]  hit;
   logic [1:0]  load;
   logic        is_write;

   // -----------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      q_next = q_reg;
      // two-flop synchronisers; only the second stage is read
      q_next.sync_s = {q_reg.sync_s[0], link.frame_sync_n};
      q_next.clk_s  = {q_reg.clk_s[0], link.ser_clk};
      q_next.data_s = {q_reg.data_s[0], link.ser_data};
      q_next.strb_s = {q_reg.strb_s[0], link.load_strobe_n};
      q_next.clk_prev  = q_reg.clk_s[1];
      q_next.strb_prev = q_reg.strb_s[1];
      q_next.done = 1'b0;

      clk_fall    = q_reg.clk_prev & ~q_reg.clk_s[1];
      strobe_fall = q_reg.strb_prev & ~q_reg.strb_s[1];
      done_now    = 1'b0;
      word        = {q_reg.shift[22:0], q_reg.data_s[1]};

      // shift in on falling edges while framed
      if (q_reg.sync_s[1]) begin
         q_next.count = 5'h0;
      end else if (clk_fall && q_reg.count < 5'(`WORD_BITS)) begin
         q_next.shift = word;
         q_next.count = q_reg.count + 5'h1;
         if (q_reg.count == 5'(`WORD_BITS - 1)) begin
            done_now = 1'b1;
         end
      end
      q_next.done = done_now;

      // field decode; bits 23:22 are never looked at
      cmd  = word[`COMMAND_CODE_MSB:`COMMAND_CODE_LSB];
      addr = word[`CHANNEL_ADDR_MSB:`CHANNEL_ADDR_LSB];
      data = word[15:0];
      is_write = (cmd == `CMD_WRITE_IN) || (cmd == `CMD_WRITE_UPD_ALL)
                 || (cmd == `CMD_WRITE_UPD_N);
      hit[0] = (addr == `ADDR_CH_A) || (addr == `ADDR_ALL);
      hit[1] = (addr == `ADDR_CH_B) || (addr == `ADDR_ALL);

      // per-channel write, load and power handling
      for (int i = 0; i < 2; i++) begin
         if (done_now && is_write && hit[i]) begin
            q_next.in_reg[i] = data;
            q_next.dirty[i]  = 1'b1;
         end
         // every load source merges into one update per cycle
         load[i] = (strobe_fall & ~q_reg.mode[i])
                 | (done_now & is_write & hit[i]
                    & (q_reg.mode[i] | ~q_reg.strb_s[1]))
                 | (done_now & hit[i]
                    & ((cmd == `CMD_UPDATE_N)
                       | (cmd == `CMD_WRITE_UPD_N)))
                 | (done_now & (cmd == `CMD_WRITE_UPD_ALL));
         // output register changes only on load of fresh data or on software reset
         if (load[i] && q_next.dirty[i]) begin
            q_next.out_reg[i] = q_next.in_reg[i];
            q_next.dirty[i]   = 1'b0;
         end // otherwise held latched
         if (done_now && cmd == `CMD_POWER && word[i]) begin
            // address and don't-care bits ignored
            q_next.pwr[i] = power_mode_t'(
               word[`POWER_MODE_HI:`POWER_MODE_LO]);
         end
      end

      // load mode setup reads only bits 1:0
      if (done_now && cmd == `CMD_LOAD_MODE) begin
         q_next.mode = word[1:0];
      end

      // software reset wins over everything else in its cycle
      if (done_now && cmd == `CMD_RESET) begin
         q_next.in_reg  = '0;
         q_next.out_reg = '0;
         q_next.dirty   = 2'h0;
         if (word[0]) begin
            q_next.mode = `LOAD_MODE_RESET;
            q_next.pwr  = {PWR_NORMAL, PWR_NORMAL};
         end
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q_reg           <= '0;
         q_reg.sync_s    <= 2'h3;
         q_reg.strb_s    <= 2'h3;
         q_reg.strb_prev <= 1'b1;
         q_reg.mode      <= `LOAD_MODE_RESET;
      end else begin
         q_reg <= q_next;
      end
   end

   // -----------------------------------------------------------------
   // outputs, all from flops
   // -----------------------------------------------------------------
   assign word_done  = q_reg.done;
   assign in_code    = q_reg.in_reg;
   assign out_code   = q_reg.out_reg;
   assign power_mode = q_reg.pwr;
   assign load_mode  = q_reg.mode;

endmodule : dac_device
`default_nettype wire

// ---- verilog/dac_host.sv ----
`include "dac_link_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dac_host (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   dac_link_if.host         link,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata
);
   import dac_link_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      host_state_t st;
      logic [2:0]  cnt;
      logic [4:0]  bits;
      logic [23:0] shift;
      logic        sync_n;
      logic        sclk;
      logic        sdata;
      logic        strobe_n;
      logic [31:0] rdata;
   } host_state_reg_t;

   host_state_reg_t q_reg;
   host_state_reg_t q_next;
   logic            half_end;

   // -----------------------------------------------------------------
   // register port and serial sequencer
   // -----------------------------------------------------------------
   always_comb begin
      q_next   = q_reg;
      half_end = (q_reg.cnt == 3'(`SER_HALF_CYCLES - 1));
      q_next.cnt = half_end ? 3'h0 : q_reg.cnt + 3'h1;
      // read data stands only in the cycle after the strobe
      q_next.rdata = 32'h0;
      if (rd) begin
         case (addr)
            `HOST_REG_STROBE: q_next.rdata = {31'h0, q_reg.strobe_n};
            `HOST_REG_STATUS: q_next.rdata = {30'h0, q_reg.strobe_n,
                                              q_reg.st != H_IDLE};
            default:          q_next.rdata = 32'h0;
         endcase
      end
      // strobe level under software; pulse it for a joint update
      if (wr && addr == `HOST_REG_STROBE) begin
         q_next.strobe_n = wdata[0];
      end
      case (q_reg.st)
         H_IDLE: begin
            q_next.cnt = 3'h0;
            if (wr && addr == `HOST_REG_WORD) begin
               q_next.shift  = wdata[23:0];
               q_next.bits   = 5'h0;
               q_next.sync_n = 1'b0;
               q_next.st     = H_LEAD;
            end
         end
         H_LEAD, H_FALL: begin
            if (half_end) begin
               if (q_reg.bits == 5'(`WORD_BITS)) begin
                  q_next.sync_n = 1'b1;
                  q_next.st     = H_GAP;
               end else begin
                  // data changes on the rising edge
                  q_next.sclk  = 1'b1;
                  q_next.sdata = q_reg.shift[23];
                  q_next.shift = {q_reg.shift[22:0], 1'b0};
                  q_next.st    = H_RISE;
               end
            end
         end
         H_RISE: begin
            if (half_end) begin
               q_next.sclk = 1'b0;
               q_next.bits = q_reg.bits + 5'h1;
               q_next.st   = H_FALL;
            end
         end
         H_GAP: begin
            if (half_end) begin
               q_next.st = H_IDLE;
            end
         end
         default: begin
            q_next.st = H_IDLE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q_reg          <= '0;
         q_reg.st       <= H_IDLE;
         q_reg.sync_n   <= 1'b1;
         q_reg.strobe_n <= 1'b1;
      end else begin
         q_reg <= q_next;
      end
   end

   // pins and read data straight from flops
   assign link.frame_sync_n  = q_reg.sync_n;
   assign link.ser_clk       = q_reg.sclk;
   assign link.ser_data      = q_reg.sdata;
   assign link.load_strobe_n = q_reg.strobe_n;
   assign rdata              = q_reg.rdata;

endmodule : dac_host
`default_nettype wire

// ---- sim/dac_link_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_link_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic frame_sync_n,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic load_strobe_n
);
   logic [4:0] fall_cnt_reg;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // falling link clock edges seen inside the current frame
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) fall_cnt_reg <= 5'h00;
      else if (frame_sync_n) fall_cnt_reg <= 5'h00;
      else if ($fell(ser_clk)) fall_cnt_reg <= fall_cnt_reg + 5'h01;
   end

   property p_idle_clk; frame_sync_n |-> !ser_clk; endproperty
   a_idle_clk: assert property (p_idle_clk)
      else $error("link clock high outside frame");
   property p_data_fall; $fell(ser_clk) |-> $stable(ser_data); endproperty
   a_data_fall: assert property (p_data_fall)
      else $error("data moved at falling edge");
   property p_high; $rose(ser_clk) |-> ser_clk[*4] ##1 !ser_clk; endproperty
   a_high: assert property (p_high)
      else $error("link clock high phase wrong");
   property p_low;
      $fell(ser_clk) && !frame_sync_n |-> !ser_clk[*4];
   endproperty
   a_low: assert property (p_low)
      else $error("link clock low phase short");
   property p_lead;
      $fell(frame_sync_n) |-> !ser_clk[*4] ##1 ser_clk;
   endproperty
   a_lead: assert property (p_lead)
      else $error("frame lead wrong");
   property p_gap; $rose(frame_sync_n) |-> frame_sync_n[*4]; endproperty
   a_gap: assert property (p_gap)
      else $error("frame gap short");
   property p_count; $rose(frame_sync_n) |-> fall_cnt_reg == 5'h18; endproperty
   a_count: assert property (p_count)
      else $error("frame did not carry 24 edges");
   property p_max; fall_cnt_reg <= 5'h18; endproperty
   a_max: assert property (p_max)
      else $error("more than 24 edges in frame");
endmodule : dac_link_asserts
`default_nettype wire

// ---- sim/dual_dac_load_update_control_tb_top.sv ----
`include "dac_link_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_dac_load_update_control_tb_top;
   import dac_link_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic [7:0]  addr    = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic        wr      = 1'b0;
   logic        rd      = 1'b0;
   logic [31:0] rdata;
   logic        word_done;
   code_pair_t  in_code;
   code_pair_t  out_code;
   power_pair_t power_mode;
   logic [1:0]  load_mode;
   logic [31:0] v;
   int          err_count = 0;
   int          cmp_count = 0;

   always #50 sys_clk = ~sys_clk;
   dac_link_if dac_link_if_i ();
   dac_host dac_host_i (.sys_clk(sys_clk), .rst(rst), .link(dac_link_if_i),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   dac_device dac_device_i (.sys_clk(sys_clk), .rst(rst),
      .link(dac_link_if_i), .word_done(word_done), .in_code(in_code),
      .out_code(out_code), .power_mode(power_mode), .load_mode(load_mode));
   dac_link_asserts dac_link_asserts_i (.sys_clk(sys_clk), .rst(rst),
      .frame_sync_n(dac_link_if_i.frame_sync_n),
      .ser_clk(dac_link_if_i.ser_clk), .ser_data(dac_link_if_i.ser_data),
      .load_strobe_n(dac_link_if_i.load_strobe_n));

   // ---------------------------------------------------------------
   // bus and link helpers
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : bus_rd
   function automatic logic [23:0] mk(logic [2:0] c, logic [2:0] a, logic [15:0] d);
      return {2'b00, c, a, d};
   endfunction : mk
   // one full word, then wait for the device to act on it
   task automatic send(input logic [23:0] w);
      int n;
      bus_wr(`HOST_REG_WORD, {8'h00, w});
      for (n = 0; n < 400 && word_done !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
      end
      chk("word_done", 32'h1, {31'h0, word_done});
      repeat (8) @(posedge sys_clk);
   endtask : send
   task automatic strobe(input logic s);
      bus_wr(`HOST_REG_STROBE, {31'h0, s});
      repeat (8) @(posedge sys_clk);
   endtask : strobe

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk("load_mode", 32'h0, 32'(load_mode));
      bus_rd(`HOST_REG_STATUS);
      chk("status", 32'h2, v);
      bus_rd(8'h10);
      chk("unmapped", 32'h0, v);
      $display("reset test done");
   endtask : t_reset
   task automatic t_load();
      send(mk(`CMD_WRITE_IN, `ADDR_CH_A, 16'h1234));
      chk("in_a", 32'h1234, 32'(in_code[0]));
      chk("out_a", 32'h0, 32'(out_code[0]));
      strobe(1'b0);
      chk("out_a", 32'h1234, 32'(out_code[0]));
      send(mk(`CMD_WRITE_IN, `ADDR_CH_B, 16'h5678));
      chk("out_b", 32'h5678, 32'(out_code[1]));
      strobe(1'b1);
      $display("load test done");
   endtask : t_load
   task automatic t_mode();
      send(24'hf7fffd);
      chk("load_mode", 32'h1, 32'(load_mode));
      send(mk(`CMD_WRITE_IN, `ADDR_CH_A, 16'h0f0f));
      chk("out_a", 32'h0f0f, 32'(out_code[0]));
      send(mk(`CMD_WRITE_IN, `ADDR_CH_B, 16'h3c3c));
      chk("out_b", 32'h5678, 32'(out_code[1]));
      strobe(1'b0);
      chk("out_b", 32'h3c3c, 32'(out_code[1]));
      strobe(1'b1);
      $display("mode test done");
   endtask : t_mode
   // software update commands and the written-since rule
   task automatic t_update();
      strobe(1'b0);
      chk("out_b", 32'h3c3c, 32'(out_code[1]));
      strobe(1'b1);
      send(mk(`CMD_WRITE_IN, `ADDR_CH_B, 16'h1111));
      chk("out_b", 32'h3c3c, 32'(out_code[1]));
      send(mk(`CMD_UPDATE_N, `ADDR_CH_B, 16'h0));
      chk("out_b", 32'h1111, 32'(out_code[1]));
      send(mk(`CMD_WRITE_UPD_N, `ADDR_CH_B, 16'h2222));
      chk("out_b", 32'h2222, 32'(out_code[1]));
      send(mk(`CMD_WRITE_UPD_ALL, `ADDR_CH_A, 16'h3333));
      chk("out_a", 32'h3333, 32'(out_code[0]));
      chk("out_b", 32'h2222, 32'(out_code[1]));
      send(24'h280000);
      chk("keep_mode", 32'h1, 32'(load_mode));
      chk("clr_out", 32'h0, 32'(out_code));
      $display("update test done");
   endtask : t_update
   task automatic t_power();
      for (int i = 0; i < 4; i++) begin
         send({2'b00, `CMD_POWER, 3'h0, 10'h0, i[1:0], 4'h2});
         chk("pwr_b", i, 32'(power_mode[1]));
         chk("pwr_a", 32'h0, 32'(power_mode[0]));
      end
      send(24'h280001);
      chk("clr_mode", 32'h0, 32'(load_mode));
      chk("clr_pwr", 32'h0, 32'(power_mode));
      chk("clr_out", 32'h0, 32'(out_code));
      $display("power test done");
   endtask : t_power

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   // watchdog well beyond the expected run
   initial begin
      #1000000;
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_load();
      t_mode();
      t_update();
      t_power();
      report_and_stop();
   end
endmodule : dual_dac_load_update_control_tb_top
`default_nettype wire
